/* File: hdl/cdw_pkg.sv */
`default_nettype none
package cdw_pkg;

  // ---------------------------------------------------------------
  // way select schemes
  // ---------------------------------------------------------------
  typedef enum logic {
    CDW_SEL_ENABLE,
    CDW_SEL_ENCODED
  } cdw_sel_e;

  // ---------------------------------------------------------------
  // split cache modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CDW_SPLIT_NONE,
    CDW_SPLIT_ID,
    CDW_SPLIT_US,
    CDW_SPLIT_BOTH
  } cdw_split_e;

  // ---------------------------------------------------------------
  // counts and widths
  // ---------------------------------------------------------------
  localparam int CDW_IDX_W   = 10;
  localparam int CDW_BLK_W   = 2;
  localparam int CDW_BE_W    = 4;
  localparam int CDW_WAYS    = 2;
  localparam int CDW_TAGS    = 2;
  localparam int CDW_CACHES  = 4;
  localparam int CDW_WAY_W   = 2;

  // ---------------------------------------------------------------
  // processor cycle type
  // ---------------------------------------------------------------
  typedef struct packed {
    logic instr;
    logic superv;
  } cdw_cyc_s;

endpackage : cdw_pkg
`default_nettype wire

/* File: hdl/cdw_way_select.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - processor index goes to data buffer address in same cycle as tag buffer; monitor index goes to the tag buffer only.
// - data entry addressed by index, way, block address and byte enables.
// - read access starts with index and block before way known; byte enables come with the way match.
// - enable scheme: only the matching way gets output enable on the shared data lines; encoded scheme: way 0 gets it for any match.
// - enable scheme: each way match drives its chip select group, gated by byte enables; encoded scheme: way 0 group serves any match.
// - encoded way bits drive the address bits between index and block of one deeper RAM.
// - cycle type selects which split cache serves each bus cycle.
// - arbiter grants shared buses so no two sources drive at once.
// - processor may use instruction cache while monitor uses data cache.
// - context flush invalidates user cache only in US and BOTH split modes; NONE and ID modes flush all four caches.
// - global hit only when all paralleled tag RAMs report a match.
module cdw_way_select #(
  parameter int IDX_W  = cdw_pkg::CDW_IDX_W,
  parameter int BLK_W  = cdw_pkg::CDW_BLK_W,
  parameter int BE_W   = cdw_pkg::CDW_BE_W,
  parameter int WAYS   = cdw_pkg::CDW_WAYS,
  parameter int TAGS   = cdw_pkg::CDW_TAGS,
  parameter int WAY_W  = cdw_pkg::CDW_WAY_W
) (
  // clock and reset
  input  wire logic                   I_CLK_SYS,
  input  wire logic                   I_RST_B,
  // configuration
  input  wire cdw_pkg::cdw_sel_e      I_SEL_MODE,
  input  wire cdw_pkg::cdw_split_e    I_SPLIT_MODE,
  // processor request
  input  wire logic                   I_CPU_REQ,
  input  wire logic                   I_CPU_RD,
  input  wire cdw_pkg::cdw_cyc_s      I_CPU_CYC,
  input  wire logic [IDX_W-1:0]       I_CPU_IDX,
  input  wire logic [BLK_W-1:0]       I_CPU_BLK,
  input  wire logic [BE_W-1:0]        I_CPU_BE,
  // bus monitor request
  input  wire logic                   I_MON_REQ,
  input  wire cdw_pkg::cdw_cyc_s      I_MON_CYC,
  input  wire logic [IDX_W-1:0]       I_MON_IDX,
  input  wire logic [BLK_W-1:0]       I_MON_BLK,
  input  wire logic [BE_W-1:0]        I_MON_BE,
  // flush
  input  wire logic                   I_CTX_FLUSH,
  // tag buffer results, per tag ram per way, active high match
  input  wire logic [TAGS*WAYS-1:0]   I_TAG_MATCH,
  input  wire logic [WAY_W-1:0]       I_WAY_MATCH_REPLACE_SELECT,
  // tag buffer address
  output logic [IDX_W-1:0]            O_TAG_IDX,
  output logic                        O_GLOBAL_MATCH_N,
  // data buffer address and enables
  output logic [IDX_W+WAY_W+BLK_W-1:0] O_DB_ADDR,
  output logic [WAYS*BE_W-1:0]        O_DB_CS,
  output logic [WAYS-1:0]             O_DB_OE,
  // split cache grants
  output logic [cdw_pkg::CDW_CACHES-1:0] O_CPU_CACHE_SEL,
  output logic [cdw_pkg::CDW_CACHES-1:0] O_MON_CACHE_SEL,
  output logic [cdw_pkg::CDW_CACHES-1:0] O_FLUSH_CACHE
);

  // refuse shapes the way decode and cache map cannot serve
  if (WAYS < 1 || WAYS > 4 || (1 << WAY_W) < WAYS || TAGS < 1) begin : g_bad
    $error("cdw_way_select: unsupported ways or tag width");
  end

  // ---------------------------------------------------------------
  // cache selection from cycle type
  // ---------------------------------------------------------------
  function automatic logic [3:0] cache_of(cdw_pkg::cdw_split_e m,
                                          cdw_pkg::cdw_cyc_s c);
    logic [1:0] n;
    n = 2'h0;
    case (m)
      cdw_pkg::CDW_SPLIT_ID:   n = {1'b0, c.instr};
      cdw_pkg::CDW_SPLIT_US:   n = {1'b0, c.superv};
      cdw_pkg::CDW_SPLIT_BOTH: n = {c.superv, c.instr};
      default:                 n = 2'h0;
    endcase
    cache_of = 4'h1 << n;
  endfunction

  logic [3:0] cpu_c;
  logic [3:0] mon_c;
  logic       cpu_win;
  logic       mon_win;
  logic [3:0] cpu_sel_q;
  logic [3:0] mon_sel_q;
  logic [3:0] flush_q;
  logic       busy_q;
  logic [IDX_W-1:0] idx_q;
  logic [BLK_W-1:0] blk_q;
  logic [BE_W-1:0]  be_q;
  logic       rd_q;

  always_comb begin
    cpu_c   = cache_of(I_SPLIT_MODE, I_CPU_CYC);
    mon_c   = cache_of(I_SPLIT_MODE, I_MON_CYC);
    // processor first; monitor runs alongside on another cache
    cpu_win = I_CPU_REQ;
    mon_win = I_MON_REQ && !(I_CPU_REQ && ((cpu_c & mon_c) != 4'h0));
  end

  // ---------------------------------------------------------------
  // grants
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      cpu_sel_q <= 4'h0;
      mon_sel_q <= 4'h0;
    end else begin
      cpu_sel_q <= cpu_win ? cpu_c : 4'h0;
      mon_sel_q <= mon_win ? mon_c : 4'h0;
    end
  end

  a_no_bus_clash: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_B)
    (cpu_sel_q & mon_sel_q) == 4'h0)
    else $error("cpu and monitor share a cache");
  a_mon_parallel: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_B)
    (I_CPU_REQ && I_MON_REQ && (cpu_c & mon_c) == 4'h0)
    |=> mon_sel_q != 4'h0 && cpu_sel_q != 4'h0)
    else $error("monitor blocked on a free cache");
  a_split_pick: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_B)
    (I_CPU_REQ && I_SPLIT_MODE == cdw_pkg::CDW_SPLIT_ID && I_CPU_CYC.instr)
    |=> cpu_sel_q == 4'h2)
    else $error("wrong split cache chosen");

  // user caches are number 0 in US mode, numbers 0 and 1 in BOTH mode (superv bit clear)
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      flush_q <= 4'h0;
    end else if (I_CTX_FLUSH) begin
      case (I_SPLIT_MODE)
        cdw_pkg::CDW_SPLIT_US:   flush_q <= 4'h1;
        cdw_pkg::CDW_SPLIT_BOTH: flush_q <= 4'h3;
        default:                 flush_q <= 4'hf;
      endcase
    end else begin
      flush_q <= 4'h0;
    end
  end

  a_flush_user: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_B)
    (I_CTX_FLUSH && I_SPLIT_MODE == cdw_pkg::CDW_SPLIT_US)
    |=> flush_q == 4'h1)
    else $error("supervisor cache flushed");
  a_flush_both: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_B)
    (I_CTX_FLUSH && I_SPLIT_MODE == cdw_pkg::CDW_SPLIT_BOTH)
    |=> flush_q == 4'h3)
    else $error("supervisor caches flushed");

  // ---------------------------------------------------------------
  // shared address, sent to tag and data buffers together
  // ---------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      idx_q  <= '0;
      blk_q  <= '0;
      be_q   <= '0;
      rd_q   <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      busy_q <= cpu_win;
      rd_q   <= cpu_win && I_CPU_RD;
      if (cpu_win) begin
        idx_q <= I_CPU_IDX;
        blk_q <= I_CPU_BLK;
        be_q  <= I_CPU_BE;
      end else if (mon_win) begin
        idx_q <= I_MON_IDX;
        blk_q <= I_MON_BLK;
        be_q  <= I_MON_BE;
      end
    end
  end

  // ---------------------------------------------------------------
  // way match combining
  // ---------------------------------------------------------------
  logic [WAYS-1:0] way_hit;
  genvar w;
  generate
    for (w = 0; w < WAYS; w++) begin : g_way
      logic [TAGS-1:0] col;
      genvar t;
      for (t = 0; t < TAGS; t++) begin : g_tag
        assign col[t] = I_TAG_MATCH[t*WAYS+w];
      end
      assign way_hit[w] = &col;
    end
  endgenerate

  // ---------------------------------------------------------------
  // data buffer outputs; address registered, enables from match
  // ---------------------------------------------------------------
  logic [IDX_W+WAY_W+BLK_W-1:0] addr_q;
  logic [WAYS*BE_W-1:0]         cs_q;
  logic [WAYS-1:0]              oe_q;
  logic                         match_n_q;

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      addr_q <= '0;
    end else if (cpu_win) begin
      // way bits zero until the tag compare resolves
      addr_q <= {I_CPU_IDX, {WAY_W{1'b0}}, I_CPU_BLK};
    end else if (I_SEL_MODE == cdw_pkg::CDW_SEL_ENCODED && busy_q) begin
      addr_q <= {idx_q, I_WAY_MATCH_REPLACE_SELECT, blk_q};
    end
  end

  a_idx_same: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_B)
    $past(cpu_win) |-> addr_q[IDX_W+WAY_W+BLK_W-1 -: IDX_W] == idx_q)
    else $error("data and tag index differ");

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      cs_q      <= '0;
      oe_q      <= '0;
      match_n_q <= 1'b1;
    end else begin
      match_n_q <= !(busy_q && (way_hit != '0));
      for (int i = 0; i < WAYS; i++) begin
        if (I_SEL_MODE == cdw_pkg::CDW_SEL_ENCODED) begin
          // one deep ram: way 0 enables serve all
          cs_q[i*BE_W +: BE_W] <= (i == 0 && busy_q && way_hit != '0)
                                  ? be_q : '0;
          oe_q[i] <= (i == 0) && busy_q && rd_q && (way_hit != '0);
        end else begin
          cs_q[i*BE_W +: BE_W] <= (busy_q && way_hit[i])
                                  ? be_q : '0;
          oe_q[i] <= busy_q && rd_q && way_hit[i];
        end
      end
    end
  end

  a_oe_onehot: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_B)
    $onehot0(oe_q))
    else $error("more than one way drives data");
  a_miss_quiet: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_B)
    (busy_q && way_hit == '0) |=> (oe_q == '0 && cs_q == '0))
    else $error("enable asserted on miss");
  a_global_match: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_B)
    !match_n_q |-> $past(busy_q) && ($past(way_hit) != '0))
    else $error("global match without full match");
  a_cs_be: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_B)
    (I_SEL_MODE == cdw_pkg::CDW_SEL_ENABLE && busy_q && way_hit[0])
    |=> cs_q[BE_W-1:0] == $past(be_q))
    else $error("chip select not gated by byte enables");

  always_comb begin
    O_TAG_IDX        = idx_q;
    O_DB_ADDR        = addr_q;
    O_DB_CS          = cs_q;
    O_DB_OE          = oe_q;
    O_GLOBAL_MATCH_N = match_n_q;
    O_CPU_CACHE_SEL  = cpu_sel_q;
    O_MON_CACHE_SEL  = mon_sel_q;
    O_FLUSH_CACHE    = flush_q;
  end

endmodule // cdw_way_select
`default_nettype wire

/* File: bench/cdw_tag_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// tag buffer stand-in: per tag ram per way match, encoded way
// ---------------------------------------------------------------
module cdw_tag_model #(
  parameter int WAYS  = cdw_pkg::CDW_WAYS,
  parameter int TAGS  = cdw_pkg::CDW_TAGS,
  parameter int WAY_W = cdw_pkg::CDW_WAY_W
) (
  // bench control
  input  wire logic             i_hit,
  input  wire logic [WAY_W-1:0] i_way,
  input  wire logic [TAGS-1:0]  i_tag_ok,
  // tag buffer results
  output logic [TAGS*WAYS-1:0]  o_match,
  output logic [WAY_W-1:0]      o_way
);
  // a cleared tag_ok bit models one paralleled tag ram missing
  always_comb begin
    for (int t = 0; t < TAGS; t++) begin
      for (int w = 0; w < WAYS; w++) begin
        o_match[t*WAYS+w] = i_hit && i_tag_ok[t] && (w == int'(i_way));
      end
    end
  end
  assign o_way = i_way;
endmodule // cdw_tag_model
`default_nettype wire

/* File: bench/tb_cache_data_buffer_way_select.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_cache_data_buffer_way_select;
  // ---------------------------------------------------------------
  // stimulus and results
  // ---------------------------------------------------------------
  logic                clk    = 1'h0;
  logic                rst_b  = 1'h0;
  cdw_pkg::cdw_sel_e   sel    = cdw_pkg::CDW_SEL_ENABLE;
  cdw_pkg::cdw_split_e split  = cdw_pkg::CDW_SPLIT_NONE;
  logic                creq   = 1'h0;
  logic                crd    = 1'h1;
  logic                mreq   = 1'h0;
  logic                flush  = 1'h0;
  logic                hit    = 1'h0;
  cdw_pkg::cdw_cyc_s   ccyc   = '0;
  cdw_pkg::cdw_cyc_s   mcyc   = '0;
  logic [9:0]          cidx   = 10'h0;
  logic [1:0]          cblk   = 2'h0;
  logic [3:0]          cbe    = 4'h0;
  logic [1:0]          way    = 2'h0;
  logic [1:0]          tok    = 2'h3;
  logic [3:0]          tmatch;
  logic [1:0]          twsel;
  logic [9:0]          tag_idx;
  logic                gmn;
  logic [13:0]         db_addr;
  logic [7:0]          cs;
  logic [1:0]          oe;
  logic [3:0]          csel;
  logic [3:0]          msel;
  logic [3:0]          fl;
  int                  errors = 0;
  int                  n_tests = 0;
  int                  cyc = 0;

  cdw_way_select dut (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_SEL_MODE(sel),
    .I_SPLIT_MODE(split), .I_CPU_REQ(creq), .I_CPU_RD(crd), .I_CPU_CYC(ccyc),
    .I_CPU_IDX(cidx), .I_CPU_BLK(cblk), .I_CPU_BE(cbe), .I_MON_REQ(mreq),
    .I_MON_CYC(mcyc), .I_MON_IDX(10'h2a5), .I_MON_BLK(2'h1), .I_MON_BE(4'hf),
    .I_CTX_FLUSH(flush), .I_TAG_MATCH(tmatch),
    .I_WAY_MATCH_REPLACE_SELECT(twsel), .O_TAG_IDX(tag_idx),
    .O_GLOBAL_MATCH_N(gmn), .O_DB_ADDR(db_addr), .O_DB_CS(cs), .O_DB_OE(oe),
    .O_CPU_CACHE_SEL(csel), .O_MON_CACHE_SEL(msel), .O_FLUSH_CACHE(fl));
  cdw_tag_model tag (.i_hit(hit), .i_way(way), .i_tag_ok(tok),
    .o_match(tmatch), .o_way(twsel));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      errors++;
      $display("[FAIL] run length exp done got hung");
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  // one cpu request (plus optional monitor), returns settled in c1
  task automatic go(input cdw_pkg::cdw_cyc_s cy, input logic [9:0] ix,
                    input logic [3:0] be, input logic m);
    @(posedge clk);
    creq <= 1'h1;
    ccyc <= cy;
    cidx <= ix;
    cblk <= ix[1:0];
    cbe  <= be;
    mreq <= m;
    @(posedge clk);
    creq <= 1'h0;
    mreq <= 1'h0;
    #1;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // reset values seen just after release
  task automatic t_reset();
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    #1;
    chk("reset_match_n", 16'h1, 16'(gmn));
    chk("reset_cs", 16'h0, 16'(cs));
    chk("reset_oe", 16'h0, 16'(oe));
    chk("reset_grant", 16'h0, 16'({csel, msel, fl}));
  endtask
  // both select schemes, both ways; full hit, half tag, miss
  task automatic t_hit();
    logic [1:0]  c;
    logic [9:0]  ix;
    logic [3:0]  be;
    logic        ok;
    logic [7:0]  ecs;
    logic [1:0]  eoe;
    logic [13:0] ea;
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 8; k++) begin
        c   = 2'(k >> 1);
        ix  = 10'(k * 73 + s * 300);
        be  = k[0] ? 4'ha : 4'h5;
        ok  = (c == 2'h0);
        // reads hit way 1 in the enable scheme, way 0 in the encoded one
        ecs = ok ? 8'(be) << (s ? 0 : 4 * k[0]) : 8'h0;
        eoe = (ok && k[0] != s[0]) ? 2'h1 << (s ? 0 : k[0]) : 2'h0;
        ea  = s ? {ix, 1'h0, k[0], ix[1:0]} : {ix, 2'h0, ix[1:0]};
        @(posedge clk);
        sel <= cdw_pkg::cdw_sel_e'(s);
        way <= {1'h0, k[0]};
        hit <= (c != 2'h3);
        tok <= (c == 2'h1) ? 2'h1 : (c == 2'h2) ? 2'h2 : 2'h3;
        crd <= (k[0] != s[0]);
        go('0, ix, be, 1'h0);
        chk("tag_idx", 16'(ix), 16'(tag_idx));
        chk("db_addr_early", 16'({ix, 2'h0, ix[1:0]}), 16'(db_addr));
        @(posedge clk);
        #1;
        chk("db_cs", 16'(ecs), 16'(cs));
        chk("db_oe", 16'(eoe), 16'(oe));
        chk("global_match_n", 16'(!ok), 16'(gmn));
        chk("db_addr_way", 16'(ea), 16'(db_addr));
      end
    end
    @(posedge clk);
    hit <= 1'h0;
  endtask
  task automatic t_split();
    logic [1:0] c;
    logic [1:0] n;
    for (int m = 0; m < 4; m++) begin
      for (int i = 0; i < 4; i++) begin
        c = 2'(i);
        n = (m == 3) ? {c[0], c[1]} : (m == 1) ? {1'h0, c[1]}
          : (m == 2) ? {1'h0, c[0]} : 2'h0;
        @(posedge clk);
        split <= cdw_pkg::cdw_split_e'(m);
        go(cdw_pkg::cdw_cyc_s'(c), 10'h3c, 4'hf, 1'h0);
        chk("cpu_cache_sel", 16'(4'h1 << n), 16'(csel));
      end
    end
  endtask
  // cpu on instruction cache, monitor on data cache, then a clash
  task automatic t_conc();
    @(posedge clk);
    split <= cdw_pkg::CDW_SPLIT_ID;
    mcyc  <= 2'h0;
    go(2'h2, 10'h11, 4'h3, 1'h1);
    chk("cpu_sel_par", 16'h2, 16'(csel));
    chk("mon_sel_par", 16'h1, 16'(msel));
    @(posedge clk);
    mcyc  <= 2'h2;
    go(2'h2, 10'h12, 4'h3, 1'h1);
    chk("cpu_sel_clash", 16'h2, 16'(csel));
    chk("mon_sel_clash", 16'h0, 16'(msel));
    // monitor alone owns the shared index
    @(posedge clk);
    mreq <= 1'h1;
    @(posedge clk);
    mreq <= 1'h0;
    #1;
    chk("cpu_sel_idle", 16'h0, 16'(csel));
    chk("mon_sel_alone", 16'h2, 16'(msel));
    chk("mon_tag_idx", 16'h2a5, 16'(tag_idx));
  endtask
  task automatic t_flush();
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      split <= cdw_pkg::cdw_split_e'(m);
      @(posedge clk);
      flush <= 1'h1;
      @(posedge clk);
      flush <= 1'h0;
      #1;
      chk("flush", (m == 2) ? 16'h1 : (m == 3) ? 16'h3 : 16'hf, 16'(fl));
      @(posedge clk);
      #1;
      chk("flush_end", 16'h0, 16'(fl));
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence and verdict
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_hit();
    t_split();
    t_conc();
    t_flush();
    give_verdict();
  end
endmodule // tb_cache_data_buffer_way_select
`default_nettype wire
